// ==== pmcc_pkg.sv ====
// constants, register map and mode type of the power mode and clock controller
`default_nettype none
package pmcc_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   // register byte offsets
   localparam logic [4:0] OFF_PLL_CONTROL_REGISTER = 5'h00;
   localparam logic [4:0] OFF_PLL_DIV = 5'h04;
   localparam logic [4:0] OFF_REGULATOR_CONTROL_REGISTER = 5'h08;
   localparam logic [4:0] OFF_MODE_CMD = 5'h0c;
   localparam logic [4:0] OFF_STATUS = 5'h10;
   localparam logic [4:0] OFF_APPLIED = 5'h14;
   // pll control register fields
   localparam int PC_HALF_BIT = 0;
   localparam int PC_OFF_BIT = 1;
   localparam int PC_BYPASS_BIT = 8;
   localparam int PC_MULT_LSB = 9;
   localparam int MULT_W = 6;
   localparam logic [5:0] MULT_RESET = 6'h0a;
   // clock divider register fields
   localparam int DIV_SYS_LSB = 0;
   localparam int SYS_W = 4;
   localparam int DIV_CORE_LSB = 4;
   localparam int CORE_W = 2;
   localparam logic [3:0] SYS_RATIO_RESET = 4'h5;
   localparam logic [1:0] CORE_RATIO_RESET = 2'h0;
   localparam logic [3:0] SYS_RATIO_BAD = 4'h0;
   // regulator control register fields
   localparam int VR_SW_LSB = 0;
   localparam int VR_SW_W = 2;
   localparam int VR_LVL_LSB = 4;
   localparam int VR_LVL_W = 4;
   localparam int VR_BYP_BIT = 8;
   localparam logic [1:0] VR_SW_OFF = 2'h0;
   localparam logic [1:0] VR_SW_RESET = 2'h3;
   localparam logic [3:0] VR_LVL_RESET = 4'hb;
   localparam int MV_W = 12;
   localparam logic [11:0] VSTEP_MV = 12'h032;
   localparam logic [11:0] VBASE_MV = 12'h320;
   // mode command codes and status fields
   localparam int CMD_W = 2;
   localparam logic [1:0] CMD_RUN = 2'h0;
   localparam logic [1:0] CMD_SLEEP = 2'h1;
   localparam logic [1:0] CMD_DEEP = 2'h2;
   localparam int ST_ERR_BIT = 8;
   localparam int MODE_W = 6;
   localparam int BOOT_CYCLES = 16;
   localparam int BOOT_W = 5;
   typedef enum logic [5:0] {
      PM_FULLON = 6'h01,
      PM_ACTIVE = 6'h02,
      PM_SLEEP = 6'h04,
      PM_DEEP = 6'h08,
      PM_HIBER = 6'h10,
      PM_BOOT = 6'h20
   } pmcc_mode_t;
endpackage
`default_nettype wire

// ==== pmcc_clk_div.sv ====
// clock divider with gating that changes only on period boundaries
`default_nettype none
module pmcc_clk_div #(
   parameter int DIV_W = 4,
   parameter logic [3:0] RESET_DIV = 4'h1
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // source ticks and control
   input wire logic srcTick,
   input wire logic runReq,
   input wire logic [DIV_W-1:0] divisor,
   // divided clock
   output logic tick,
   output logic running
);
   logic [DIV_W-1:0] cnt_reg, cnt_next, div_reg, div_next;
   logic run_reg, run_next, tick_reg, tick_next;
   logic boundary;

   // divisor and gate are latched only at the end of a full period: no truncated pulse
   always_comb begin
      boundary = srcTick && (cnt_reg >= div_reg - 1'b1);
      cnt_next = cnt_reg;
      div_next = div_reg;
      run_next = run_reg;
      if (boundary) begin
         cnt_next = '0;
         div_next = divisor;
         run_next = runReq;
      end else if (srcTick) begin
         cnt_next = cnt_reg + 1'b1;
      end
      tick_next = boundary && run_next;
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cnt_reg <= '0;
         div_reg <= RESET_DIV[DIV_W-1:0];
         run_reg <= 1'b1;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         div_reg <= div_next;
         run_reg <= run_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;
   assign running = run_reg;
endmodule
`default_nettype wire

// ==== pmcc_vreg.sv ====
// regulator control: on/off decision and voltage target in millivolts
`default_nettype none
module pmcc_vreg (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // control
   input wire logic enable,
   input wire logic bypassReq,
   input wire logic [pmcc_pkg::VR_LVL_W-1:0] level,
   // results
   output logic regOn,
   output logic [pmcc_pkg::MV_W-1:0] vintMv
);
   import pmcc_pkg::*;
   logic regOn_reg, regOn_next;
   logic [MV_W-1:0] mv_reg, mv_next;

   function automatic logic [MV_W-1:0] levelToMv(input logic [VR_LVL_W-1:0] lvl);
      logic [MV_W+VR_LVL_W-1:0] prod;
      prod = VSTEP_MV * lvl;
      return VBASE_MV + prod[MV_W-1:0];
   endfunction

   always_comb begin
      regOn_next = enable && !bypassReq;
      mv_next = levelToMv(level);
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         regOn_reg <= 1'b1;
         mv_reg <= VBASE_MV + VSTEP_MV * VR_LVL_RESET;
      end else begin
         regOn_reg <= regOn_next;
         mv_reg <= mv_next;
      end
   end

   assign regOn = regOn_reg;
   assign vintMv = mv_reg;
endmodule
`default_nettype wire

// ==== pmcc_top.sv ====
// power mode sequencer, clock control registers and clock dividers
//
// Chosen here: the strobed register port and the register offsets.
`default_nettype none
// Summary of operation
// - full-on runs pll not bypassed, enabled unless entered from deep sleep with it off; it is the mode after reset
// - active mode keeps pll enabled unless software switches it off, but bypassed; clocks run at input rate
// - multiplier writes accepted in active, applied only on entering full-on
// - active mode allows dma to on-chip memories
// - pll may be disabled in active; it must be on before full-on or sleep, though deep sleep exit with bypass clear enters full-on with it off
// - sleep gates core clock, keeps pll and system clock running
// - wakeup in sleep samples the bypass bit to pick the resumed mode
// - sleep allows dma to external memory only
// - deep sleep gates core and system clocks
// - deep sleep blocks asynchronous peripheral accesses
// - deep sleep ends only on the reset pin
// - deep sleep exit goes full-on if bypass clear, active if set
// - writing 00 to the regulator switch field in full-on or active enters hibernate, clocks stopped
// - in hibernate the external pins are released to high impedance
// - reset pin in hibernate restarts the regulator and runs a boot sequence
// - voltage target comes from the regulator level field in 50 mV steps
// - the regulator may be disabled and bypassed by software
// - pll output is input clock times a programmable 0.5x to 63x factor
// - multiplier defaults to 10x after reset
// - divider writes change derived clocks at the next period boundary, no mode change needed
// - system clock is pll output divided by system ratio 1 to 15
// - system ratio changes take effect without pll relock
// - core ratio codes 0 to 3 divide pll output by 1, 2, 4, 8
module pmcc_top (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // register port
   input wire logic [pmcc_pkg::ADDR_W-1:0] regAddr,
   input wire logic [pmcc_pkg::DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [pmcc_pkg::DATA_W-1:0] regRdata,
   // external events
   input wire logic wakeup,
   input wire logic resetPin,
   // pll output edges from the analog pll
   input wire logic vcoTick,
   // clock control
   output logic coreTick,
   output logic sysTick,
   output logic coreClkOn,
   output logic sysClkOn,
   output logic pllEnable,
   output logic pllBypass,
   output logic pllHalfInput,
   output logic [pmcc_pkg::MULT_W-1:0] pllMultiplier,
   // access permissions and pins
   output logic dmaOnChipAllow,
   output logic dmaExtAllow,
   output logic asyncAccessAllow,
   output logic pinOutEnN,
   // regulator and sequencing
   output logic regulatorOn,
   output logic [pmcc_pkg::MV_W-1:0] vintMillivolts,
   output logic bootStart,
   output logic [pmcc_pkg::MODE_W-1:0] modeState
);
   import pmcc_pkg::*;

   pmcc_mode_t mode_reg, mode_next;
   logic [MULT_W-1:0] mult_reg, mult_next, multApplied_reg, multApplied_next;
   logic half_reg, half_next, halfApplied_reg, halfApplied_next;
   logic pllOff_reg, pllOff_next, bypass_reg, bypass_next;
   logic [SYS_W-1:0] sysRatio_reg, sysRatio_next;
   logic [CORE_W-1:0] coreRatio_reg, coreRatio_next;
   logic [VR_SW_W-1:0] vrSw_reg, vrSw_next;
   logic [VR_LVL_W-1:0] vrLvl_reg, vrLvl_next;
   logic vrByp_reg, vrByp_next, err_reg, err_next;
   logic [BOOT_W-1:0] bootCnt_reg, bootCnt_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic pllEn_reg, pllEn_next, pllByp_reg, pllByp_next;
   logic dmaOn_reg, dmaOn_next, dmaExt_reg, dmaExt_next, async_reg, async_next;
   logic pinEnN_reg, pinEnN_next, boot_reg, boot_next;
   logic wrPll, wrDiv, wrVr, wrCmd, wrStat, refuse, enterHiber;
   logic coreRun, sysRun, srcTick;
   logic [SYS_W-1:0] coreDivisor;
   logic [CMD_W-1:0] cmdCode;

   // core ratio code to divisor
   function automatic logic [SYS_W-1:0] coreDiv(input logic [CORE_W-1:0] code);
      return SYS_W'(1) << code;
   endfunction

   // resume mode chosen by the bypass bit
   function automatic pmcc_mode_t resumeMode(input logic byp);
      return byp ? PM_ACTIVE : PM_FULLON;
   endfunction

   always_comb begin
      wrPll = regWr && (regAddr == OFF_PLL_CONTROL_REGISTER);
      wrDiv = regWr && (regAddr == OFF_PLL_DIV);
      wrVr = regWr && (regAddr == OFF_REGULATOR_CONTROL_REGISTER);
      wrCmd = regWr && (regAddr == OFF_MODE_CMD);
      wrStat = regWr && (regAddr == OFF_STATUS);
      cmdCode = regWdata[CMD_W-1:0];
      enterHiber = wrVr && (regWdata[VR_SW_LSB +: VR_SW_W] == VR_SW_OFF);
   end

   // mode sequencer
   always_comb begin
      mode_next = mode_reg;
      refuse = 1'b0;
      bootCnt_next = '0;
      case (mode_reg)
         PM_FULLON, PM_ACTIVE: begin
            if (enterHiber) begin
               mode_next = PM_HIBER;
            end else if (wrCmd) begin
               case (cmdCode)
                  CMD_RUN: begin
                     if (bypass_reg) begin
                        mode_next = PM_ACTIVE;
                     end else if (pllOff_reg) begin
                        refuse = 1'b1;
                     end else begin
                        mode_next = PM_FULLON;
                     end
                  end
                  CMD_SLEEP: begin
                     if (pllOff_reg) begin
                        refuse = 1'b1;
                     end else begin
                        mode_next = PM_SLEEP;
                     end
                  end
                  CMD_DEEP: mode_next = PM_DEEP;
                  default: refuse = 1'b1;
               endcase
            end
         end
         PM_SLEEP: begin
            if (wakeup) begin
               mode_next = resumeMode(bypass_reg);
            end
         end
         PM_DEEP: begin
            // wakeup is deliberately not looked at here
            if (resetPin) begin
               mode_next = resumeMode(bypass_reg);
            end
         end
         PM_HIBER: begin
            if (resetPin) begin
               mode_next = PM_BOOT;
            end
         end
         PM_BOOT: begin
            bootCnt_next = bootCnt_reg + 1'b1;
            if (bootCnt_reg == BOOT_W'(BOOT_CYCLES - 1)) begin
               mode_next = PM_FULLON;
               bootCnt_next = '0;
            end
         end
         default: mode_next = PM_FULLON;
      endcase
   end

   // control fields; hibernate exit reloads them, the internal supply having been off
   always_comb begin
      mult_next = mult_reg;
      half_next = half_reg;
      pllOff_next = pllOff_reg;
      bypass_next = bypass_reg;
      sysRatio_next = sysRatio_reg;
      coreRatio_next = coreRatio_reg;
      vrSw_next = vrSw_reg;
      vrLvl_next = vrLvl_reg;
      vrByp_next = vrByp_reg;
      multApplied_next = multApplied_reg;
      halfApplied_next = halfApplied_reg;
      if (mode_reg == PM_HIBER && mode_next == PM_BOOT) begin
         mult_next = MULT_RESET;
         half_next = 1'b0;
         pllOff_next = 1'b0;
         bypass_next = 1'b0;
         sysRatio_next = SYS_RATIO_RESET;
         coreRatio_next = CORE_RATIO_RESET;
         vrSw_next = VR_SW_RESET;
         vrLvl_next = VR_LVL_RESET;
         vrByp_next = 1'b0;
      end else begin
         if (wrPll) begin
            mult_next = regWdata[PC_MULT_LSB +: MULT_W];
            half_next = regWdata[PC_HALF_BIT];
            bypass_next = regWdata[PC_BYPASS_BIT];
            // the pll may only be switched off in active mode
            if (mode_reg == PM_ACTIVE || !regWdata[PC_OFF_BIT]) begin
               pllOff_next = regWdata[PC_OFF_BIT];
            end
         end
         if (wrDiv) begin
            coreRatio_next = regWdata[DIV_CORE_LSB +: CORE_W];
            if (regWdata[DIV_SYS_LSB +: SYS_W] != SYS_RATIO_BAD) begin
               sysRatio_next = regWdata[DIV_SYS_LSB +: SYS_W];
            end
         end
         if (wrVr) begin
            vrSw_next = regWdata[VR_SW_LSB +: VR_SW_W];
            vrLvl_next = regWdata[VR_LVL_LSB +: VR_LVL_W];
            vrByp_next = regWdata[VR_BYP_BIT];
         end
      end
      // new ratio reaches the pll only when full-on is entered
      if (mode_next == PM_FULLON && mode_reg != PM_FULLON) begin
         multApplied_next = mult_reg;
         halfApplied_next = half_reg;
      end
   end

   // derived outputs, aligned with the mode register
   always_comb begin
      err_next = (err_reg && !(wrStat && regWdata[ST_ERR_BIT])) || refuse; // set wins
      pllEn_next = !pllOff_next && (mode_next != PM_DEEP) && (mode_next != PM_HIBER);
      case (mode_next)
         PM_FULLON: pllByp_next = 1'b0;
         PM_SLEEP: pllByp_next = pllByp_reg;
         default: pllByp_next = 1'b1;
      endcase
      dmaOn_next = (mode_next == PM_FULLON) || (mode_next == PM_ACTIVE);
      dmaExt_next = dmaOn_next || (mode_next == PM_SLEEP);
      async_next = dmaExt_next || (mode_next == PM_BOOT);
      pinEnN_next = (mode_next == PM_HIBER);
      boot_next = (mode_next == PM_BOOT) && (mode_reg == PM_HIBER);
      coreRun = (mode_reg == PM_FULLON) || (mode_reg == PM_ACTIVE) || (mode_reg == PM_BOOT);
      sysRun = coreRun || (mode_reg == PM_SLEEP);
      // bypassed or stopped pll: dividers count the input clock itself
      srcTick = pllByp_reg || !pllEn_reg || vcoTick;
      coreDivisor = coreDiv(coreRatio_reg);
   end

   // register read; data stand only in the cycle after the strobe
   always_comb begin
      rdata_next = '0;
      if (regRd) begin
         case (regAddr)
            OFF_PLL_CONTROL_REGISTER: begin
               rdata_next[PC_MULT_LSB +: MULT_W] = mult_reg;
               rdata_next[PC_HALF_BIT] = half_reg;
               rdata_next[PC_OFF_BIT] = pllOff_reg;
               rdata_next[PC_BYPASS_BIT] = bypass_reg;
            end
            OFF_PLL_DIV: begin
               rdata_next[DIV_SYS_LSB +: SYS_W] = sysRatio_reg;
               rdata_next[DIV_CORE_LSB +: CORE_W] = coreRatio_reg;
            end
            OFF_REGULATOR_CONTROL_REGISTER: begin
               rdata_next[VR_SW_LSB +: VR_SW_W] = vrSw_reg;
               rdata_next[VR_LVL_LSB +: VR_LVL_W] = vrLvl_reg;
               rdata_next[VR_BYP_BIT] = vrByp_reg;
            end
            OFF_STATUS: begin
               rdata_next[MODE_W-1:0] = mode_reg;
               rdata_next[ST_ERR_BIT] = err_reg;
            end
            OFF_APPLIED: begin
               rdata_next[PC_MULT_LSB +: MULT_W] = multApplied_reg;
               rdata_next[PC_HALF_BIT] = halfApplied_reg;
            end
            default: rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         mode_reg <= PM_FULLON;
         mult_reg <= MULT_RESET;
         multApplied_reg <= MULT_RESET;
         half_reg <= 1'b0;
         halfApplied_reg <= 1'b0;
         pllOff_reg <= 1'b0;
         bypass_reg <= 1'b0;
         sysRatio_reg <= SYS_RATIO_RESET;
         coreRatio_reg <= CORE_RATIO_RESET;
         vrSw_reg <= VR_SW_RESET;
         vrLvl_reg <= VR_LVL_RESET;
         vrByp_reg <= 1'b0;
         err_reg <= 1'b0;
         bootCnt_reg <= '0;
         rdata_reg <= '0;
         pllEn_reg <= 1'b1;
         pllByp_reg <= 1'b0;
         dmaOn_reg <= 1'b1;
         dmaExt_reg <= 1'b1;
         async_reg <= 1'b1;
         pinEnN_reg <= 1'b0;
         boot_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         mult_reg <= mult_next;
         multApplied_reg <= multApplied_next;
         half_reg <= half_next;
         halfApplied_reg <= halfApplied_next;
         pllOff_reg <= pllOff_next;
         bypass_reg <= bypass_next;
         sysRatio_reg <= sysRatio_next;
         coreRatio_reg <= coreRatio_next;
         vrSw_reg <= vrSw_next;
         vrLvl_reg <= vrLvl_next;
         vrByp_reg <= vrByp_next;
         err_reg <= err_next;
         bootCnt_reg <= bootCnt_next;
         rdata_reg <= rdata_next;
         pllEn_reg <= pllEn_next;
         pllByp_reg <= pllByp_next;
         dmaOn_reg <= dmaOn_next;
         dmaExt_reg <= dmaExt_next;
         async_reg <= async_next;
         pinEnN_reg <= pinEnN_next;
         boot_reg <= boot_next;
      end
   end

   // core and system dividers; gate changes wait for a period boundary
   pmcc_clk_div #(.DIV_W(SYS_W), .RESET_DIV(SYS_W'(1))) coreDivInst (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .srcTick(srcTick),
      .runReq(coreRun),
      .divisor(coreDivisor),
      .tick(coreTick),
      .running(coreClkOn)
   );

   pmcc_clk_div #(.DIV_W(SYS_W), .RESET_DIV(SYS_RATIO_RESET)) sysDivInst (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .srcTick(srcTick),
      .runReq(sysRun),
      .divisor(sysRatio_reg),
      .tick(sysTick),
      .running(sysClkOn)
   );

   pmcc_vreg vregInst (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .enable(mode_next != PM_HIBER),
      .bypassReq(vrByp_reg),
      .level(vrLvl_reg),
      .regOn(regulatorOn),
      .vintMv(vintMillivolts)
   );

   assign regRdata = rdata_reg;
   assign pllEnable = pllEn_reg;
   assign pllBypass = pllByp_reg;
   assign pllHalfInput = halfApplied_reg;
   assign pllMultiplier = multApplied_reg;
   assign dmaOnChipAllow = dmaOn_reg;
   assign dmaExtAllow = dmaExt_reg;
   assign asyncAccessAllow = async_reg;
   assign pinOutEnN = pinEnN_reg;
   assign bootStart = boot_reg;
   assign modeState = mode_reg;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   mult_apply_a: assert property ($changed(multApplied_reg) |->
      mode_reg == PM_FULLON && $past(mode_reg) != PM_FULLON) else $error("multiplier applied outside full-on entry");
   active_bypass_a: assert property (mode_reg == PM_ACTIVE |-> pllBypass && dmaOnChipAllow)
      else $error("active mode not bypassed");
   fullon_pll_a: assert property (mode_reg == PM_FULLON |-> pllEnable && !pllBypass)
      else $error("full-on without running pll");
   sleep_core_a: assert property ($rose(mode_reg == PM_SLEEP) && pllBypass |->
      ##[1:9] (!coreClkOn && sysClkOn)) else $error("core clock not gated in sleep");
   wake_sel_a: assert property (mode_reg == PM_SLEEP && wakeup |=>
      mode_reg == ($past(bypass_reg) ? PM_ACTIVE : PM_FULLON)) else $error("wrong mode after wakeup");
   sleep_dma_a: assert property (mode_reg == PM_SLEEP |-> !dmaOnChipAllow && dmaExtAllow)
      else $error("on-chip dma open in sleep");
   deep_hold_a: assert property (mode_reg == PM_DEEP && !resetPin |=> mode_reg == PM_DEEP && !asyncAccessAllow)
      else $error("deep sleep left without reset pin");
   deep_exit_a: assert property (mode_reg == PM_DEEP && resetPin |=>
      mode_reg == ($past(bypass_reg) ? PM_ACTIVE : PM_FULLON)) else $error("wrong mode after deep sleep");
   hiber_entry_a: assert property ((mode_reg == PM_FULLON || mode_reg == PM_ACTIVE) && enterHiber |=>
      mode_reg == PM_HIBER && !regulatorOn && pinOutEnN) else $error("hibernate not entered");
   hiber_boot_a: assert property (mode_reg == PM_HIBER && resetPin |=> bootStart ##16 mode_reg == PM_FULLON)
      else $error("boot sequence not run");
   sys_zero_a: assert property (wrDiv && regWdata[DIV_SYS_LSB +: SYS_W] == SYS_RATIO_BAD |=>
      $stable(sysRatio_reg)) else $error("zero system ratio accepted");
   pll_on_a: assert property (pllOff_reg && wrCmd && cmdCode == CMD_SLEEP |=>
      $stable(mode_reg) && err_reg) else $error("sleep entered with pll off");

   sleep_wake_c: cover property (mode_reg == PM_SLEEP ##1 mode_reg == PM_ACTIVE);
   deep_exit_c: cover property (mode_reg == PM_DEEP ##1 mode_reg == PM_FULLON);
   hiber_boot_c: cover property (mode_reg == PM_HIBER ##1 mode_reg == PM_BOOT);
   refuse_c: cover property (refuse);
endmodule
`default_nettype wire

// ==== pmcc_wake_model.sv ====
// far-side model: wakeup source, reset pin driver and pll output edges
`default_nettype none
module pmcc_wake_model (
   // clock
   input wire logic sys_clk,
   // requests from the bench
   input wire logic wakeReq,
   input wire logic rstReq,
   input wire logic pllOn,
   // pins toward the device
   output logic wakeup,
   output logic resetPin,
   output logic vcoTick
);
   timeunit 1ns;
   timeprecision 1ps;
   // pll edges every second cycle, so bypass shows as a faster clock
   initial begin
      wakeup = 1'b0;
      resetPin = 1'b0;
      vcoTick = 1'b0;
   end
   always @(posedge sys_clk) begin
      wakeup <= wakeReq;
      resetPin <= rstReq;
      // a stopped pll gives no edges at all
      vcoTick <= pllOn & ~vcoTick;
   end
endmodule
`default_nettype wire

// ==== pmcc_tb.sv ====
// self-checking bench for the power mode and clock controller
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pmcc_pkg::*;
   logic sys_clk, rstn, regWr, regRd, wakeReq, rstReq, wakeup, resetPin, vcoTick;
   logic [ADDR_W-1:0] regAddr;
   logic [DATA_W-1:0] regWdata, regRdata, rv, pv;
   logic coreTick, sysTick, coreClkOn, sysClkOn, pllEnable, pllBypass, pllHalfInput;
   logic dmaOnChipAllow, dmaExtAllow, asyncAccessAllow, pinOutEnN, regulatorOn, bootStart;
   logic [MULT_W-1:0] pllMultiplier;
   logic [MV_W-1:0] vintMillivolts;
   logic [MODE_W-1:0] modeState;
   int err_total = 0;
   int total_checks = 0;
   pmcc_top dut_u (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .wakeup(wakeup), .resetPin(resetPin), .vcoTick(vcoTick),
      .coreTick(coreTick), .sysTick(sysTick), .coreClkOn(coreClkOn), .sysClkOn(sysClkOn),
      .pllEnable(pllEnable), .pllBypass(pllBypass), .pllHalfInput(pllHalfInput), .pllMultiplier(pllMultiplier),
      .dmaOnChipAllow(dmaOnChipAllow), .dmaExtAllow(dmaExtAllow), .asyncAccessAllow(asyncAccessAllow),
      .pinOutEnN(pinOutEnN), .regulatorOn(regulatorOn), .vintMillivolts(vintMillivolts),
      .bootStart(bootStart), .modeState(modeState));
   pmcc_wake_model partner_u (.sys_clk(sys_clk), .wakeReq(wakeReq), .rstReq(rstReq), .pllOn(pllEnable),
      .wakeup(wakeup), .resetPin(resetPin), .vcoTick(vcoTick));
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge sys_clk);
      regWr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1;
      d = regRdata;
   endtask
   // cycles between two ticks of the core (s=0) or system (s=1) clock
   task automatic per(input bit s, output logic [15:0] n);
      n = 16'h0000;
      repeat (200) begin
         @(posedge sys_clk);
         #1;
         if ((s ? sysTick : coreTick) === 1'b1) break;
      end
      repeat (200) begin
         @(posedge sys_clk);
         #1;
         n = n + 16'h0001;
         if ((s ? sysTick : coreTick) === 1'b1) break;
      end
   endtask
   initial begin
      #200000;
      err_total++;
      results();
   end
   initial begin
      rstn = 1'b0;
      {regWr, regRd, wakeReq, rstReq} = 4'h0;
      regAddr = '0;
      regWdata = '0;
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      #1;
      chk(16'(modeState), 16'h0001);
      chk(16'(pllMultiplier), 16'h000a);
      rd(OFF_PLL_CONTROL_REGISTER, rv); chk(rv, 16'h1400);
      rd(OFF_PLL_DIV, rv); chk(rv, 16'h0005);
      rd(OFF_REGULATOR_CONTROL_REGISTER, rv); chk(rv, 16'h00b3);
      rd(5'h1c, rv); chk(rv, 16'h0000);
      wr(OFF_REGULATOR_CONTROL_REGISTER, 16'h0043); repeat (3) @(posedge sys_clk); #1;
      chk(16'(vintMillivolts), 16'h03e8);
      wr(OFF_REGULATOR_CONTROL_REGISTER, 16'h01b3); repeat (3) @(posedge sys_clk); #1;
      chk(16'(regulatorOn), 16'h0000);
      wr(OFF_REGULATOR_CONTROL_REGISTER, 16'h00b3);
      wr(OFF_PLL_CONTROL_REGISTER, 16'h2900); wr(OFF_MODE_CMD, 16'h0000);
      chk(16'({modeState, pllBypass, pllEnable}), 16'h000b);
      chk(16'(pllMultiplier), 16'h000a);
      chk(16'(dmaOnChipAllow), 16'h0001);
      // divider writes land at the next boundary, so measure a later period
      for (int c = 0; c < 4; c++) begin
         wr(OFF_PLL_DIV, 16'(c * 16 + 5)); repeat (20) @(posedge sys_clk);
         per(1'b0, pv); chk(pv, 16'(1 << c));
      end
      wr(OFF_PLL_DIV, 16'h0003); repeat (20) @(posedge sys_clk);
      per(1'b1, pv); chk(pv, 16'h0003);
      wr(OFF_PLL_DIV, 16'h0000); repeat (20) @(posedge sys_clk);
      per(1'b1, pv); chk(pv, 16'h0003);
      rd(OFF_PLL_DIV, rv); chk(rv, 16'h0003);
      wr(OFF_PLL_CONTROL_REGISTER, 16'h2902); chk(16'(pllEnable), 16'h0000);
      wr(OFF_MODE_CMD, 16'h0001);
      rd(OFF_STATUS, rv); chk(rv, 16'h0102);
      wr(OFF_STATUS, 16'h0100); wr(OFF_PLL_CONTROL_REGISTER, 16'h2900);
      wr(OFF_MODE_CMD, 16'h0001);
      chk(16'({modeState, dmaOnChipAllow, dmaExtAllow}), 16'h0011);
      repeat (20) @(posedge sys_clk); #1;
      chk(16'({coreClkOn, sysClkOn, pllEnable}), 16'h0003);
      wakeReq <= 1'b1; repeat (3) @(posedge sys_clk); wakeReq <= 1'b0; #1;
      chk(16'(modeState), 16'h0002);
      wr(OFF_MODE_CMD, 16'h0002);
      wakeReq <= 1'b1; repeat (20) @(posedge sys_clk); wakeReq <= 1'b0; #1;
      chk(16'(modeState), 16'h0008);
      chk(16'({coreClkOn, sysClkOn}), 16'h0000);
      chk(16'(asyncAccessAllow), 16'h0000);
      rstReq <= 1'b1; repeat (3) @(posedge sys_clk); rstReq <= 1'b0; #1;
      chk(16'(modeState), 16'h0002);
      wr(OFF_PLL_CONTROL_REGISTER, 16'h2801); wr(OFF_MODE_CMD, 16'h0000);
      chk(16'({modeState, pllMultiplier}), 16'h0054);
      chk(16'(pllHalfInput), 16'h0001);
      rd(OFF_APPLIED, rv); chk(rv, 16'h2801);
      repeat (20) @(posedge sys_clk);
      // pll edges come every second cycle, so divisor 1 gives period 2
      per(1'b0, pv); chk(pv, 16'h0002);
      wr(OFF_REGULATOR_CONTROL_REGISTER, 16'h00b0);
      chk(16'({modeState, regulatorOn}), 16'h0020);
      chk(16'(pinOutEnN), 16'h0001);
      // boot pulse stands only in the first boot cycle
      rstReq <= 1'b1; repeat (2) @(posedge sys_clk); #1;
      chk(16'(bootStart), 16'h0001);
      @(posedge sys_clk); rstReq <= 1'b0; #1;
      chk(16'({modeState, regulatorOn}), 16'h0041);
      repeat (BOOT_CYCLES + 4) @(posedge sys_clk); #1;
      chk(16'({modeState, pllMultiplier}), 16'h004a);
      results();
   end
endmodule
`default_nettype wire
